// ==== fsk_pkg.sv ====
package fsk_pkg;
	// ************************************************************
	// command and reply codes
	// ************************************************************
	localparam logic [7:0] CMD_FAN_RPT = 8'h10;
	localparam logic [7:0] CMD_FAN_PWR = 8'h11;
	localparam logic [7:0] CMD_DEV_INFO = 8'h12;
	localparam logic [7:0] CMD_TEMP_RPT = 8'h13;
	localparam logic [7:0] CMD_BUS_XACT = 8'h14;
	localparam logic [7:0] CMD_LCD_DIRECT = 8'h16;
	localparam logic [7:0] CMD_KEY_RPT = 8'h17;
	localparam logic [7:0] REPLY_FLAG = 8'h40;
	localparam logic [7:0] FAN_REPORT_TYPE = 8'h81;
	localparam logic [7:0] MATCH_ROM_CMD = 8'h55;
	// ************************************************************
	// field limits and reset values
	// ************************************************************
	localparam logic [7:0] FAN_PWR_MAX = 8'h64;
	localparam logic [7:0] DEV_INDEX_MAX = 8'h1F;
	localparam logic [7:0] DEV_INDEX_NOADDR = 8'h20;
	localparam logic [7:0] READ_COUNT_MAX = 8'h0E;
	localparam logic [4:0] XACT_LEN_MIN = 5'h02;
	localparam logic [4:0] XACT_LEN_MAX = 5'h10;
	localparam logic [5:0] KEY_MASK_ALL = 6'h3F;
	localparam logic [7:0] FAN_PWR_RESET = 8'h64;
	localparam int KEY_UP_BIT = 0;
	localparam int KEY_ENTER_BIT = 1;
	localparam int KEY_CANCEL_BIT = 2;
	localparam int KEY_LEFT_BIT = 3;
	localparam int KEY_RIGHT_BIT = 4;
	localparam int KEY_DOWN_BIT = 5;
	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_HZ = 25000000;
	localparam int SLOT_MS = 125;
	localparam int SLOT_CYC = CLK_HZ / 1000 * SLOT_MS;
	localparam int SLOTS_PER_TEMP = 8;
	// ************************************************************
	// carriers
	// ************************************************************
	typedef struct packed {
		logic [7:0] ptype;
		logic [4:0] len;
		logic [15:0][7:0] data;
	} fsk_pkt_s;
	typedef struct packed {
		logic [7:0] fan_pwr0;
		logic [7:0] fan_pwr1;
		logic [7:0] fan_pwr2;
		logic [7:0] fan_pwr3;
		logic [5:0] press_mask;
		logic [5:0] release_mask;
	} fsk_boot_s;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_WRITE = 3'b010,
		ST_READ = 3'b011,
		ST_REPLY = 3'b100
	} fsk_state_e;
endpackage : fsk_pkg

// ==== fsk_cmd_handler.sv ====
// Summary of operation
// - nonzero setup byte starts 500 ms fan reports
// - fan reports staggered one eighth second apart
// - reported fan forced full power one slot
// - fan power needs four bytes 0..100
// - fan power replies 0x51 empty
// - fan power levels go to boot state
// - power-up bus scan fills device table
// - info query index 0..31, nine byte reply
// - thermometer family codes report every second
// - 32-bit mask enables temperature reports
// - transaction carries 2..16 bytes, limits checked
// - index 32 skips address phase
// - found index sends match plus address
// - write length minus two bytes after address
// - read count bytes read into reply
// - display command forwarded, empty reply
// - all key events reported after reset
// - masks select reported press and release
// - key masks go to boot state
`timescale 1ns/100ps
`default_nettype none
module fsk_cmd_handler
	import fsk_pkg::*;
#(
	parameter int SLOT_CYCLES = SLOT_CYC,
	parameter logic [7:0] THERMO_FAMILY_A = 8'hA1, // arbitrary family code
	parameter logic [7:0] THERMO_FAMILY_B = 8'hA2 // arbitrary family code
)
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic cmd_valid,
	input var fsk_pkt_s cmd_pkt,
	output logic cmd_ready,
	output logic rsp_valid,
	output var fsk_pkt_s rsp_pkt,
	input wire logic rsp_ready,
	output logic fan_rpt_valid,
	output logic [1:0] fan_rpt_index,
	input wire logic [3:0] fan_enable,
	output logic [3:0] fan_force_full,
	output logic [31:0][7:0] fan_power,
	output var fsk_boot_s boot_cfg,
	input wire logic enum_valid,
	input wire logic [4:0] enum_index,
	input wire logic [63:0] enum_rom,
	output logic temp_rpt_valid,
	output logic [31:0] temp_rpt_mask,
	output logic bus_op_valid,
	output logic bus_op_read,
	output logic [7:0] bus_op_wdata,
	input wire logic bus_op_done,
	input wire logic [7:0] bus_op_rdata,
	output logic lcd_cmd_valid,
	output logic [7:0] lcd_cmd_byte,
	input wire logic key_event_valid,
	input wire logic key_event_press,
	input wire logic [5:0] key_event_bits,
	output logic key_rpt_valid,
	output logic key_rpt_press,
	output logic [5:0] key_rpt_bits
);
	// ************************************************************
	// state
	// ************************************************************
	fsk_state_e state_r;
	fsk_pkt_s cmd_r;
	fsk_pkt_s rsp_r;
	logic [3:0][7:0] fan_pwr_r;
	logic [5:0] press_mask_r, release_mask_r;
	logic fan_rpt_on_r;
	logic [31:0] temp_mask_r;
	logic [31:0] dev_found_r;
	logic [31:0] thermo_r;
	logic [63:0] rom_tab_r [32];
	logic [31:0] slot_cnt_r;
	logic [2:0] slot_r;
	logic [3:0] xact_idx_r;
	logic [3:0] xact_left_r;
	logic op_busy_r;
	logic [7:0] op_data_r;
	logic op_read_r;
	logic fan_rpt_r, temp_rpt_r, lcd_r, key_r, key_press_r;
	logic [1:0] fan_idx_r;
	logic [5:0] key_bits_r;
	logic [7:0] lcd_byte_r;
	logic accept;
	logic cmd_ok;
	logic [4:0] wr_len;
	function automatic logic in_range(input logic [7:0] v, input logic [7:0] maxv);
		in_range = (v <= maxv);
	endfunction : in_range
	assign cmd_ready = (state_r == ST_IDLE);
	assign accept = cmd_valid && cmd_ready;
	assign rsp_valid = (state_r == ST_REPLY);
	assign rsp_pkt = rsp_r;
	assign wr_len = cmd_r.len - XACT_LEN_MIN;
	// ************************************************************
	// command validation
	// ************************************************************
	always_comb
	begin
		unique case (cmd_pkt.ptype)
			CMD_FAN_RPT: cmd_ok = (cmd_pkt.len == 5'd1);
			CMD_FAN_PWR: cmd_ok = (cmd_pkt.len == 5'd4) && in_range(cmd_pkt.data[0], FAN_PWR_MAX) &&
				in_range(cmd_pkt.data[1], FAN_PWR_MAX) && in_range(cmd_pkt.data[2], FAN_PWR_MAX) &&
				in_range(cmd_pkt.data[3], FAN_PWR_MAX);
			CMD_DEV_INFO: cmd_ok = (cmd_pkt.len == 5'd1) && in_range(cmd_pkt.data[0], DEV_INDEX_MAX);
			CMD_TEMP_RPT: cmd_ok = (cmd_pkt.len == 5'd4);
			CMD_BUS_XACT: cmd_ok = (cmd_pkt.len >= XACT_LEN_MIN) && (cmd_pkt.len <= XACT_LEN_MAX) &&
				in_range(cmd_pkt.data[0], DEV_INDEX_NOADDR) && in_range(cmd_pkt.data[1], READ_COUNT_MAX) &&
				((cmd_pkt.data[0] == DEV_INDEX_NOADDR) || dev_found_r[cmd_pkt.data[0][4:0]]);
			CMD_LCD_DIRECT: cmd_ok = (cmd_pkt.len == 5'd1);
			CMD_KEY_RPT: cmd_ok = (cmd_pkt.len == 5'd2);
			default: cmd_ok = 1'b0;
		endcase
	end
	// ************************************************************
	// device table, filled during power-up enumeration
	// ************************************************************
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			dev_found_r <= '0;
			thermo_r <= '0;
		end
		else if (enum_valid)
		begin
			dev_found_r[enum_index] <= 1'b1;
			thermo_r[enum_index] <= (enum_rom[7:0] == THERMO_FAMILY_A) || (enum_rom[7:0] == THERMO_FAMILY_B);
		end
	end
	always_ff @(posedge ref_clk)
	begin
		if (enum_valid)
			rom_tab_r[enum_index] <= enum_rom;
	end
	// ************************************************************
	// persistent settings
	// ************************************************************
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			fan_pwr_r <= {4{FAN_PWR_RESET}};
			press_mask_r <= KEY_MASK_ALL;
			release_mask_r <= KEY_MASK_ALL;
			fan_rpt_on_r <= 1'b0;
			temp_mask_r <= '0;
		end
		else if (accept && cmd_ok)
		begin
			unique case (cmd_pkt.ptype)
				CMD_FAN_RPT: fan_rpt_on_r <= (cmd_pkt.data[0] != 8'h00);
				CMD_FAN_PWR: fan_pwr_r <= cmd_pkt.data[3:0];
				CMD_TEMP_RPT: temp_mask_r <= {cmd_pkt.data[3], cmd_pkt.data[2], cmd_pkt.data[1], cmd_pkt.data[0]};
				CMD_KEY_RPT:
				begin
					press_mask_r <= cmd_pkt.data[0][5:0];
					release_mask_r <= cmd_pkt.data[1][5:0];
				end
				default: ;
			endcase
		end
	end
	assign boot_cfg = '{fan_pwr0: fan_pwr_r[0], fan_pwr1: fan_pwr_r[1], fan_pwr2: fan_pwr_r[2],
		fan_pwr3: fan_pwr_r[3], press_mask: press_mask_r, release_mask: release_mask_r};
	assign fan_power = {224'h0, fan_pwr_r};
	// ************************************************************
	// eighth-second slot timer for fan and temperature reports
	// ************************************************************
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			slot_cnt_r <= '0;
			slot_r <= '0;
		end
		else if (slot_cnt_r == 32'(SLOT_CYCLES - 1))
		begin
			slot_cnt_r <= '0;
			slot_r <= slot_r + 3'd1;
		end
		else
			slot_cnt_r <= slot_cnt_r + 32'd1;
	end
	// each fan owns one slot of four, so reports are staggered and repeat every half second
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			fan_rpt_r <= 1'b0;
			fan_idx_r <= '0;
			temp_rpt_r <= 1'b0;
		end
		else
		begin
			fan_rpt_r <= fan_rpt_on_r && (slot_cnt_r == 32'(SLOT_CYCLES - 1)) && fan_enable[slot_r[1:0] + 2'd1];
			fan_idx_r <= slot_r[1:0] + 2'd1;
			temp_rpt_r <= (slot_cnt_r == 32'(SLOT_CYCLES - 1)) && (slot_r == 3'(SLOTS_PER_TEMP - 1)) &&
				((temp_mask_r & thermo_r) != '0);
		end
	end
	// full power only during the fan's own slot, one quarter of each half second
	always_comb
	begin
		fan_force_full = '0;
		if (fan_rpt_on_r && fan_enable[slot_r[1:0]])
			fan_force_full[slot_r[1:0]] = 1'b1;
	end
	assign fan_rpt_valid = fan_rpt_r;
	assign fan_rpt_index = fan_idx_r;
	assign temp_rpt_valid = temp_rpt_r;
	assign temp_rpt_mask = temp_mask_r;

	// ************************************************************
	// command sequencer
	// ************************************************************
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_r <= ST_IDLE;
			cmd_r <= '0;
			rsp_r <= '0;
			xact_idx_r <= '0;
			xact_left_r <= '0;
			op_busy_r <= 1'b0;
			op_data_r <= '0;
			op_read_r <= 1'b0;
			lcd_r <= 1'b0;
			lcd_byte_r <= '0;
		end
		else
		begin
			lcd_r <= 1'b0;
			unique case (state_r)
				ST_IDLE:
					if (accept && cmd_ok)
					begin
						cmd_r <= cmd_pkt;
						rsp_r <= '0;
						rsp_r.ptype <= cmd_pkt.ptype | REPLY_FLAG;
						xact_idx_r <= '0;
						if (cmd_pkt.ptype == CMD_DEV_INFO)
						begin
							rsp_r.len <= 5'd9;
							rsp_r.data[0] <= cmd_pkt.data[0];
							for (int i = 0; i < 8; i++)
								rsp_r.data[i + 1] <= rom_tab_r[cmd_pkt.data[0][4:0]][i * 8 +: 8];
						end
						if (cmd_pkt.ptype == CMD_LCD_DIRECT)
						begin
							lcd_r <= 1'b1;
							lcd_byte_r <= cmd_pkt.data[0];
						end
						if (cmd_pkt.ptype == CMD_BUS_XACT)
						begin
							if (cmd_pkt.data[0] == DEV_INDEX_NOADDR)
								state_r <= ST_WRITE;
							else
							begin
								state_r <= ST_ADDR;
								op_busy_r <= 1'b1;
								op_read_r <= 1'b0;
								op_data_r <= MATCH_ROM_CMD;
							end
						end
						else
							state_r <= ST_REPLY;
					end
				ST_ADDR:
					if (bus_op_done)
					begin
						if (xact_idx_r == 4'd8)
						begin
							op_busy_r <= 1'b0;
							xact_idx_r <= '0;
							state_r <= ST_WRITE;
						end
						else
						begin
							op_data_r <= rom_tab_r[cmd_r.data[0][4:0]][xact_idx_r[2:0] * 8 +: 8];
							xact_idx_r <= xact_idx_r + 4'd1;
						end
					end
				ST_WRITE:
					if (!op_busy_r)
					begin
						if (xact_idx_r < wr_len[3:0] && wr_len != 5'd0)
						begin
							op_busy_r <= 1'b1;
							op_read_r <= 1'b0;
							op_data_r <= cmd_r.data[xact_idx_r + 4'd2];
						end
						else
						begin
							xact_left_r <= cmd_r.data[1][3:0];
							xact_idx_r <= '0;
							rsp_r.len <= 5'(cmd_r.data[1][3:0]);
							state_r <= (cmd_r.data[1] == 8'h00) ? ST_REPLY : ST_READ;
							if (cmd_r.data[1] != 8'h00)
							begin
								op_busy_r <= 1'b1;
								op_read_r <= 1'b1;
							end
						end
					end
					else if (bus_op_done)
					begin
						op_busy_r <= 1'b0;
						xact_idx_r <= xact_idx_r + 4'd1;
					end
				ST_READ:
					if (bus_op_done)
					begin
						rsp_r.data[xact_idx_r] <= bus_op_rdata;
						xact_idx_r <= xact_idx_r + 4'd1;
						xact_left_r <= xact_left_r - 4'd1;
						if (xact_left_r == 4'd1)
						begin
							op_busy_r <= 1'b0;
							state_r <= ST_REPLY;
						end
					end
				ST_REPLY:
					if (rsp_ready)
						state_r <= ST_IDLE;
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	assign bus_op_valid = op_busy_r;
	assign bus_op_read = op_read_r;
	assign bus_op_wdata = op_data_r;
	assign lcd_cmd_valid = lcd_r;
	assign lcd_cmd_byte = lcd_byte_r;

	// ************************************************************
	// key event filter
	// ************************************************************
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			key_r <= 1'b0;
			key_press_r <= 1'b0;
			key_bits_r <= '0;
		end
		else
		begin
			key_r <= key_event_valid && ((key_event_bits & (key_event_press ? press_mask_r : release_mask_r)) != '0);
			key_press_r <= key_event_press;
			key_bits_r <= key_event_bits & (key_event_press ? press_mask_r : release_mask_r);
		end
	end

	assign key_rpt_valid = key_r;
	assign key_rpt_press = key_press_r;
	assign key_rpt_bits = key_bits_r;
endmodule : fsk_cmd_handler
`default_nettype wire

// ==== fsk_bus_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****************
// single wire bus device model
// ****************
module fsk_bus_model (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic slow,
	input wire logic bus_op_valid,
	input wire logic bus_op_read,
	input wire logic [7:0] bus_op_wdata,
	output var logic bus_op_done,
	output var logic [7:0] bus_op_rdata
);
	logic [7:0] wlog [32];
	logic [4:0] wn;
	logic [4:0] rn;
	int cnt;
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			bus_op_done <= 1'b0;
			bus_op_rdata <= 8'h00;
			cnt <= 0;
			wn <= 5'h00;
			rn <= 5'h00;
		end
		else if (bus_op_valid && !bus_op_done && cnt >= (slow ? 5 : 0))
		begin
			bus_op_done <= 1'b1;
			cnt <= 0;
			if (bus_op_read)
			begin
				bus_op_rdata <= 8'hC0 + {3'h0, rn};
				rn <= rn + 5'h01;
			end
			else
			begin
				wlog[wn] <= bus_op_wdata;
				wn <= wn + 5'h01;
			end
		end
		else
		begin
			bus_op_done <= 1'b0;
			cnt <= (bus_op_valid && !bus_op_done) ? cnt + 1 : 0;
			// released line must not look like the last answer
			bus_op_rdata <= ~bus_op_rdata;
		end
	end
endmodule : fsk_bus_model
`default_nettype wire

// ==== fsk_cmd_handler_props.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****************
// port checker
// ****************
module fsk_cmd_handler_props
	import fsk_pkg::*;
#(parameter int SLOT_CYCLES = SLOT_CYC)
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic cmd_valid,
	input var fsk_pkt_s cmd_pkt,
	input wire logic cmd_ready,
	input wire logic rsp_valid,
	input var fsk_pkt_s rsp_pkt,
	input wire logic rsp_ready,
	input wire logic fan_rpt_valid,
	input wire logic [1:0] fan_rpt_index,
	input wire logic [3:0] fan_enable,
	input wire logic [3:0] fan_force_full,
	input wire logic [31:0][7:0] fan_power,
	input var fsk_boot_s boot_cfg,
	input wire logic [31:0] temp_rpt_mask,
	input wire logic bus_op_valid,
	input wire logic bus_op_read,
	input wire logic [7:0] bus_op_wdata,
	input wire logic bus_op_done,
	input wire logic lcd_cmd_valid,
	input wire logic [7:0] lcd_cmd_byte,
	input wire logic key_event_valid,
	input wire logic key_event_press,
	input wire logic [5:0] key_event_bits,
	input wire logic key_rpt_valid
);
	logic tk;
	logic pok;
	assign tk = cmd_valid && cmd_ready;
	assign pok = cmd_pkt.data[0] <= FAN_PWR_MAX && cmd_pkt.data[1] <= FAN_PWR_MAX &&
		cmd_pkt.data[2] <= FAN_PWR_MAX && cmd_pkt.data[3] <= FAN_PWR_MAX;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	AST_KEY_FWD: assert property (key_event_valid |=> key_rpt_valid ==
		$past(|(key_event_bits & (key_event_press ? boot_cfg.press_mask : boot_cfg.release_mask))))
		else $error("key report does not follow mask");
	AST_RSP_FLAG: assert property (rsp_valid |-> rsp_pkt.ptype[6]) else $error("reply flag missing");
	AST_RSP_HOLD: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_pkt))
		else $error("reply dropped before ready");
	AST_LCD: assert property (tk && cmd_pkt.ptype == CMD_LCD_DIRECT && cmd_pkt.len == 5'h01 |=>
		lcd_cmd_valid && lcd_cmd_byte == $past(cmd_pkt.data[0]) ##1 !lcd_cmd_valid) else $error("lcd forward wrong");
	AST_FAN_PWR: assert property (tk && cmd_pkt.ptype == CMD_FAN_PWR && cmd_pkt.len == 5'h04 && pok |=>
		fan_power[0] == $past(cmd_pkt.data[0]) && boot_cfg.fan_pwr3 == $past(cmd_pkt.data[3]))
		else $error("fan power not stored");
	AST_PWR_BAD: assert property (tk && cmd_pkt.ptype == CMD_FAN_PWR && !pok |=>
		!rsp_valid && $stable(fan_power)) else $error("bad fan power took effect");
	AST_FORCE: assert property ($onehot0(fan_force_full) && (fan_force_full & ~fan_enable) == 4'h0)
		else $error("fan forced outside its slot");
	AST_FAN_GAP: assert property (fan_rpt_valid |-> fan_enable[fan_rpt_index] ##1 !fan_rpt_valid [*8])
		else $error("fan reports bunched or disabled fan");
	AST_BUS_HOLD: assert property (bus_op_valid && !bus_op_done |=> bus_op_valid &&
		$stable(bus_op_wdata) && $stable(bus_op_read)) else $error("bus op changed early");
	AST_TEMP: assert property (tk && cmd_pkt.ptype == CMD_TEMP_RPT && cmd_pkt.len == 5'h04 |=>
		temp_rpt_mask == $past(cmd_pkt.data[3:0])) else $error("temperature mask wrong");
	COV_LCD: cover property (lcd_cmd_valid);
	COV_FAN: cover property (fan_rpt_valid);
	COV_KEY: cover property (key_rpt_valid);
	COV_READ: cover property (bus_op_read && bus_op_done);
endmodule : fsk_cmd_handler_props
bind fsk_cmd_handler fsk_cmd_handler_props #(.SLOT_CYCLES(SLOT_CYCLES)) u_props (.*);
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench
	import fsk_pkg::*;
;
	// ****************
	// stimulus and checks
	// ****************
	localparam logic [63:0] ROM = 64'h0123_4567_89AB_CDA1;
	logic ref_clk, arst_n, cmd_valid, rsp_ready, enum_valid, key_event_valid, key_event_press, slow;
	logic cmd_ready, rsp_valid, fan_rpt_valid, temp_rpt_valid, bus_op_valid, bus_op_read, bus_op_done;
	logic lcd_cmd_valid, key_rpt_valid, key_rpt_press;
	fsk_pkt_s cmd_pkt, rsp_pkt, r;
	fsk_boot_s boot_cfg;
	logic [1:0] fan_rpt_index;
	logic [3:0] fan_enable, fan_force_full;
	logic [4:0] enum_index;
	logic [5:0] key_event_bits, key_rpt_bits;
	logic [7:0] bus_op_wdata, bus_op_rdata, lcd_cmd_byte;
	logic [31:0] temp_rpt_mask;
	logic [31:0][7:0] fan_power;
	logic [63:0] enum_rom;
	int err_count, compares, cyc, n, k;
	// short slot keeps the run small; each slot lasts 10 cycles, and the waits below count clock cycles
	fsk_cmd_handler #(.SLOT_CYCLES(10)) dut (.*);
	fsk_bus_model m (.*);
	initial
	begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	task summarize();
		$display("err_count=%0d compares=%0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize
	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 4000)
		begin
			err_count++;
			$display("[ERR] %0t run did not finish", $time);
			summarize();
		end
	end
	task chk(input logic [127:0] got, input logic [127:0] exp);
		compares++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] %0t got %0h expected %0h", $time, got, exp);
		end
	endtask : chk
	task send(input logic [7:0] t, input logic [4:0] l, input logic [127:0] d);
		cmd_pkt <= '{t, l, d};
		cmd_valid <= 1'b1;
		n = 0;
		do
		begin
			@(negedge ref_clk);
			n++;
		end
		while (cmd_ready !== 1'b1 && n < 50);
		chk(cmd_ready, 1'b1);
		@(posedge ref_clk);
		cmd_valid <= 1'b0;
	endtask : send
	task rsp(input logic [7:0] t, input logic [4:0] l);
		n = 0;
		do
		begin
			@(negedge ref_clk);
			n++;
		end
		while (rsp_valid !== 1'b1 && n < 400);
		chk(rsp_valid, 1'b1);
		r = rsp_pkt;
		chk(r.ptype, t);
		chk(r.len, l);
		@(posedge ref_clk);
		rsp_ready <= 1'b1;
		@(posedge ref_clk);
		rsp_ready <= 1'b0;
	endtask : rsp
	task none();
		repeat (6)
		begin
			@(negedge ref_clk);
			chk(rsp_valid, 1'b0);
		end
		@(posedge ref_clk);
	endtask : none
	task key(input logic p, input logic [5:0] b, input logic e);
		key_event_valid <= 1'b1;
		key_event_press <= p;
		key_event_bits <= b;
		@(posedge ref_clk);
		key_event_valid <= 1'b0;
		@(negedge ref_clk);
		chk(key_rpt_valid, e);
		chk(key_rpt_bits, e ? b : 6'h00);
		if (e)
			chk(key_rpt_press, p);
		@(posedge ref_clk);
	endtask : key
	initial
	begin
		arst_n = 1'b0;
		cmd_valid = 1'b0;
		cmd_pkt = '0;
		rsp_ready = 1'b0;
		fan_enable = 4'h0;
		enum_valid = 1'b0;
		enum_index = 5'h00;
		enum_rom = 64'h0;
		key_event_valid = 1'b0;
		key_event_press = 1'b0;
		key_event_bits = 6'h00;
		slow = 1'b0;
		repeat (20) @(posedge ref_clk);
		chk(fan_power[3], FAN_PWR_RESET);
		chk(boot_cfg.release_mask, KEY_MASK_ALL);
		chk(cmd_ready, 1'b1);
		arst_n <= 1'b1;
		@(posedge ref_clk);
		enum_valid <= 1'b1;
		enum_index <= 5'h03;
		enum_rom <= ROM;
		@(posedge ref_clk);
		enum_index <= 5'h1F;
		enum_rom <= ROM ^ 64'h03;
		@(posedge ref_clk);
		enum_valid <= 1'b0;
		@(posedge ref_clk);
		for (int i = 0; i < 6; i++)
		begin
			key(1'b1, 6'h01 << i, 1'b1);
			key(1'b0, 6'h01 << i, 1'b1);
		end
		send(CMD_KEY_RPT, 5'h02, 128'h2005);
		rsp(8'h57, 5'h00);
		chk(boot_cfg.press_mask, 6'h05);
		key(1'b1, 6'h02, 1'b0);
		key(1'b1, 6'h04, 1'b1);
		key(1'b0, 6'h20, 1'b1);
		key(1'b0, 6'h01, 1'b0);
		send(CMD_FAN_PWR, 5'h04, 128'h01376400);
		rsp(8'h51, 5'h00);
		chk({fan_power[1], boot_cfg.fan_pwr3}, 16'h6401);
		send(CMD_FAN_PWR, 5'h04, 128'h00006500);
		none();
		chk(fan_power[3], 8'h01);
		send(CMD_FAN_PWR, 5'h03, 128'h000000);
		none();
		send(CMD_LCD_DIRECT, 5'h01, 128'h38);
		@(negedge ref_clk);
		chk(lcd_cmd_valid, 1'b1);
		rsp(8'h56, 5'h00);
		chk(lcd_cmd_byte, 8'h38);
		send(CMD_DEV_INFO, 5'h01, 128'h03);
		rsp(8'h52, 5'h09);
		chk(r.data[8:0], {ROM, 8'h03});
		send(CMD_DEV_INFO, 5'h01, 128'h20);
		none();
		send(CMD_TEMP_RPT, 5'h04, 128'h80000008);
		rsp(8'h53, 5'h00);
		chk(temp_rpt_mask, 32'h80000008);
		@(negedge ref_clk);
		for (k = 0; k < 100 && temp_rpt_valid !== 1'b1; k++) @(negedge ref_clk);
		chk(temp_rpt_valid, 1'b1);
		@(posedge ref_clk);
		send(CMD_BUS_XACT, 5'h04, 128'h5AA50203);
		rsp(8'h54, 5'h02);
		chk(r.data[1:0], 16'hC1C0);
		chk(m.wlog[0], MATCH_ROM_CMD);
		for (int i = 0; i < 8; i++) chk(m.wlog[i + 1], ROM[8 * i +: 8]);
		chk({m.wlog[10], m.wlog[9], 3'h0, m.wn}, 24'h5AA50B);
		slow <= 1'b1;
		send(CMD_BUS_XACT, 5'h03, 128'h330020);
		rsp(8'h54, 5'h00);
		chk({m.wlog[11], 3'h0, m.wn}, 16'h330C);
		send(CMD_BUS_XACT, 5'h02, 128'h0005);
		none();
		send(CMD_BUS_XACT, 5'h02, 128'h0F03);
		none();
		chk(m.wn, 5'h0C);
		fan_enable <= 4'b0101;
		send(CMD_FAN_RPT, 5'h01, 128'h01);
		rsp(8'h50, 5'h00);
		repeat (20) @(posedge ref_clk);
		k = 0;
		repeat (80)
		begin
			@(negedge ref_clk);
			if (fan_rpt_valid === 1'b1)
			begin
				k++;
				chk(fan_enable[fan_rpt_index], 1'b1);
				chk(fan_force_full, 4'h1 << fan_rpt_index);
			end
		end
		chk(k, 4);
		summarize();
	end
endmodule : testbench
`default_nettype wire
